// >>> testbench/ram_test_access_mux_bench.sv
`timescale 1ns/1ps
`include "rtam_defs.svh"

module ram_test_access_mux_bench
    import rtam_pkg::*;
;
    logic                sys_clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                testSel = 1'b0;
    logic                quiet = 1'b0;
    logic                inject = 1'b0;
    logic                step = 1'b0;
    rtam_ram_req_t [1:0] userReq = '0;
    rtam_ram_req_t [1:0] ramReq;
    logic [1:0][1:0]     userRamOut;
    logic [1:0][1:0]     ramOut;
    logic [1:0]          dCs = '0, dRw = '0, dD0 = '0, dD1 = '0, dA = '0;
    logic [1:0]          fIn0 = '0, fIn1 = '0, uOut0 = '0, uOut1 = '0, uOe = '0;
    logic [1:0]          rOut0, rOut1, pinOe, uIn0, uIn1;
    logic [3:0]          stageCount;
    logic                carry;
    logic [1:0][1:0]     expMem [2];
    logic [1:0][1:0]     d;
    integer              seed = 32'h0BF6A13C;
    int                  n_mismatch = 0;
    int                  comparisons = 0;

    // half period of 12.5 ns gives 40 MHz
    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    rtam_access_mux #(.NUM_RAMS(2)) rtam_access_mux_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .pattern_mode_select_pin(testSel),
        .quietSelectPin(quiet), .ramPick(1'b0), .userReq(userReq), .userRamOut(userRamOut),
        .direct_chip_select_in(dCs), .direct_read_write_in(dRw), .direct_data_in_0(dD0),
        .direct_data_in_1(dD1), .direct_address_in_0(dA), .funcPinIn0(fIn0),
        .funcPinIn1(fIn1), .userPinOut0(uOut0), .userPinOut1(uOut1), .userPinOe(uOe),
        .direct_ram_out_0(rOut0), .direct_ram_out_1(rOut1), .directPinOe(pinOe),
        .userPinIn0(uIn0), .userPinIn1(uIn1), .ramReq(ramReq), .ramOut(ramOut),
        .stageClockInject(inject), .userCountStep(step), .stageCount(stageCount),
        .stageCarryMon(carry));

    rtam_ram_model #(.NUM_RAMS(2)) rtam_ram_model_i (
        .sys_clk(sys_clk), .ramReq(ramReq), .ramOut(ramOut));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    // one tester access: setup event, write events (rz strobe), read event
    task automatic access(input logic a, input logic [1:0][1:0] dv, input int writes);
        rtam_ram_req_t [1:0] expReq;
        @(negedge sys_clk);
        dCs = 2'h3;
        dRw = 2'h0;
        dA = {2{a}};
        for (int r = 0; r < 2; r++)
        begin
            dD0[r] = dv[r][0];
            dD1[r] = dv[r][1];
            expReq[r] = {1'b1, 1'b0, a, dv[r]};
        end
        if (writes > 0)
            expMem[a] = dv;
        #1 check("direct request", ramReq, expReq);
        repeat (writes)
        begin
            @(negedge sys_clk) dRw = 2'h3;
            @(negedge sys_clk) dRw = 2'h0;
        end
        #1;
        for (int r = 0; r < 2; r++)
            check("ram out pins", {rOut1[r], rOut0[r]}, expMem[a][r]);
        check("pin direction", pinOe, 2'h3);
    endtask : access

    initial
    begin
        // bound of 10,000 cycles keeps the run far inside one tester pattern
        #250000;
        n_mismatch++;
        end_sim();
    end

    initial
    begin
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk) check("count after reset", stageCount, 4'h0);
        // normal mode with random user and pin traffic, quiet pin ignored here
        repeat (60)
        begin
            @(negedge sys_clk);
            {userReq, fIn0, fIn1, uOut0, uOut1, uOe} = 20'($random(seed));
            {dCs, dRw, dD0, dD1, dA, quiet} = 11'($random(seed));
            #1 check("user request", ramReq, userReq);
            check("user ram data", userRamOut, ramOut);
            check("shared pin out", {rOut1, rOut0}, {uOut1, uOut0});
            check("shared pin oe", pinOe, uOe);
            check("shared pin in", {uIn1, uIn0}, {fIn1, fIn0});
        end
        // test mode: one address bit, so lowest and highest only
        @(negedge sys_clk);
        quiet = 1'b0;
        testSel = 1'b1;
        d = 4'($random(seed));
        access(1'b0, d, 1);
        access(1'b1, ~d, 2);
        access(1'b0, d, 0);
        access(1'b1, ~d, 0);
        @(negedge sys_clk) quiet = 1'b1;
        #1 check("quiet selects", {ramReq[1].chipSelect, ramReq[0].chipSelect}, 2'h0);
        // one injected step lands on the upper counter half once per rise
        @(negedge sys_clk) inject = 1'b1;
        repeat (4) @(negedge sys_clk);
        inject = 1'b0;
        for (int i = 0; i < 10 && stageCount !== 4'h4; i++)
            @(negedge sys_clk);
        repeat (4) @(negedge sys_clk);
        check("injected count", stageCount, 4'h4);
        // low half wraps into the upper half; the carry shows two edges later
        @(negedge sys_clk) step = 1'b1;
        repeat (4) @(negedge sys_clk);
        step = 1'b0;
        check("stepped count", stageCount, 4'h8);
        check("carry early", carry, 1'b0);
        @(negedge sys_clk) check("carry shown", carry, 1'b1);
        @(negedge sys_clk) check("carry gone", carry, 1'b0);
        // mid-run reset must clear the counter fixture again
        @(negedge sys_clk) rst_n = 1'b0;
        @(negedge sys_clk) rst_n = 1'b1;
        check("count after second reset", stageCount, 4'h0);
        @(negedge sys_clk) check("carry after second reset", carry, 1'b0);
        end_sim();
    end
endmodule : ram_test_access_mux_bench

// >>> testbench/rtam_ram_model.sv
`timescale 1ns/1ps
`include "rtam_defs.svh"

// behavioural asynchronous ram macros, one per design ram port
module rtam_ram_model
    import rtam_pkg::*;
#(
    parameter int NUM_RAMS = 2
)
(
    input  wire logic                                   sys_clk,
    input  wire rtam_ram_req_t [NUM_RAMS-1:0]           ramReq,
    output logic [NUM_RAMS-1:0][`RTAM_DATA_W-1:0]       ramOut
);
    logic [`RTAM_DATA_W-1:0] mem [NUM_RAMS][2**`RTAM_ADDR_W];
    logic [`RTAM_DATA_W-1:0] noise = 2'h1;

    // power-up contents are fixed so pass-through checks never meet unknowns
    initial
    begin
        for (int r = 0; r < NUM_RAMS; r++)
            for (int a = 0; a < 2**`RTAM_ADDR_W; a++)
                mem[r][a] = '0;
    end

    // outputs carry no data while not reading, so stale values never look valid
    always @(posedge sys_clk)
        noise <= ~noise;

    // write while select and strobe are high, read while select high and strobe low
    always @*
    begin
        for (int r = 0; r < NUM_RAMS; r++)
        begin
            if (ramReq[r].chipSelect && ramReq[r].readWrite)
                mem[r][ramReq[r].address] = ramReq[r].dataIn;
            if (ramReq[r].chipSelect && !ramReq[r].readWrite)
                ramOut[r] = mem[r][ramReq[r].address];
            else
                ramOut[r] = noise;
        end
    end
endmodule : rtam_ram_model

// >>> verilog/rtam_access_mux.sv
`timescale 1ns/1ps
`include "rtam_defs.svh"

// Notes on behaviour
// - select low: ram ports stay wired to user logic
// - select high: direct pins drive ram select, read/write, address, data
// - select high: ram outputs also appear on direct output pins
// - every ram terminal reachable from primary pins
// - test path shares functional pins through a mux
// - each ram own pins, or shared pins with a ram select
// - in test mode all ram selects can be forced low together
// - shared two-way pins fixed in direction during test mode
// - no pull-up pin carries ram data out or ram select
// - storage has a reset so short patterns initialise it
// - test inputs clock counter stages; test outputs expose internals
// - deselected ram is in standby, drawing no bit current
module rtam_access_mux
    import rtam_pkg::*;
#(
    parameter int NUM_RAMS   = `RTAM_NUM_RAMS,
    parameter int SHARE_PINS = 0
)
(
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    // test select pins
    input  wire logic                          pattern_mode_select_pin,
    input  wire logic                          quietSelectPin,
    input  wire logic [`RTAM_SEL_W-1:0]        ramPick,
    // user side
    input  wire rtam_ram_req_t [NUM_RAMS-1:0]  userReq,
    output logic [NUM_RAMS-1:0][`RTAM_DATA_W-1:0] userRamOut,
    // direct pins, one group per ram (group 0 used when shared)
    input  wire logic [NUM_RAMS-1:0]           direct_chip_select_in,
    input  wire logic [NUM_RAMS-1:0]           direct_read_write_in,
    input  wire logic [NUM_RAMS-1:0]           direct_data_in_0,
    input  wire logic [NUM_RAMS-1:0]           direct_data_in_1,
    input  wire logic [NUM_RAMS-1:0]           direct_address_in_0,
    // functional pins shared with the ram outputs as two-way pins
    input  wire logic [NUM_RAMS-1:0]           funcPinIn0,
    input  wire logic [NUM_RAMS-1:0]           funcPinIn1,
    input  wire logic [NUM_RAMS-1:0]           userPinOut0,
    input  wire logic [NUM_RAMS-1:0]           userPinOut1,
    input  wire logic [NUM_RAMS-1:0]           userPinOe,
    output logic [NUM_RAMS-1:0]                direct_ram_out_0,
    output logic [NUM_RAMS-1:0]                direct_ram_out_1,
    output logic [NUM_RAMS-1:0]                directPinOe,
    output logic [NUM_RAMS-1:0]                userPinIn0,
    output logic [NUM_RAMS-1:0]                userPinIn1,
    // ram macro side
    output rtam_ram_req_t [NUM_RAMS-1:0]       ramReq,
    input  wire logic [NUM_RAMS-1:0][`RTAM_DATA_W-1:0] ramOut,
    // counter stage test fixture
    input  wire logic                          stageClockInject,
    input  wire logic                          userCountStep,
    output logic [`RTAM_CNT_W-1:0]             stageCount,
    output logic                               stageCarryMon
);

    // the injection pin passes three flops before the counter sees it; userCountStep goes straight in
    logic [2:0] injectSync;
    logic       lowStep;
    logic [1:0] highStep;
    logic [`RTAM_CNT_W/2-1:0] lowNibble;
    logic [`RTAM_CNT_W/2-1:0] highNibble;
    // full reset word, split between the two counter halves
    localparam logic [`RTAM_CNT_W-1:0] CNT_RESET = `RTAM_CNT_RESET;

    wire logic testMode;
    wire logic quietAll;
    wire logic injectEdge;
    wire logic lowCarry;

    // mux paths ignore reset, so the tester reaches the rams before initialisation
    // a pull-up pin must never feed these; board must strap them low
    assign testMode = pattern_mode_select_pin;
    assign quietAll = testMode & quietSelectPin;

    // per ram steering; sharing picks one ram from common pins
    genvar r;
    generate
        for (r = 0; r < NUM_RAMS; r++)
        begin : g_ram
            localparam int PIN = (SHARE_PINS != 0) ? 0 : r;
            wire rtam_ram_req_t directReq;
            wire logic          ramSel;

            assign ramSel = (SHARE_PINS != 0) ? (ramPick == `RTAM_SEL_W'(r)) : 1'b1;
            // shared pins only enable the picked ram, the rest stay deselected
            assign directReq = '{chipSelect: direct_chip_select_in[PIN] & ramSel,
                                 readWrite:  direct_read_write_in[PIN],
                                 address:    direct_address_in_0[PIN],
                                 dataIn:     {direct_data_in_1[PIN], direct_data_in_0[PIN]}};

            rtam_ram_select u_sel (
                .accessSelect (testMode),
                .quietAll     (quietAll),
                .userReq      (userReq[r]),
                .directReq    (directReq),
                .ramReq       (ramReq[r])
            );

            // ram data always reaches user logic, and the pins in test mode
            assign userRamOut[r]       = ramOut[r];
            assign direct_ram_out_0[r] = testMode ? ramOut[r][0] : userPinOut0[r];
            assign direct_ram_out_1[r] = testMode ? ramOut[r][1] : userPinOut1[r];
            // whole test mode fixes these pins as outputs
            assign directPinOe[r] = testMode | userPinOe[r];
            assign userPinIn0[r]  = funcPinIn0[r];
            assign userPinIn1[r]  = funcPinIn1[r];

            AST_TEST_ROUTES: assert property (@(posedge sys_clk) disable iff (!rst_n)
                testMode && !quietAll |-> ramReq[r] == directReq)
                else $error("test mode ram request not from direct pins");
            AST_NORMAL_ROUTES: assert property (@(posedge sys_clk) disable iff (!rst_n)
                !testMode |-> ramReq[r] == userReq[r])
                else $error("normal mode ram request not from user logic");
            AST_OUT_VISIBLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
                testMode |-> directPinOe[r] && direct_ram_out_0[r] == ramOut[r][0]
                    && direct_ram_out_1[r] == ramOut[r][1])
                else $error("ram output not on direct pins in test mode");
            AST_QUIET_CS: assert property (@(posedge sys_clk) disable iff (!rst_n)
                quietAll |-> !ramReq[r].chipSelect)
                else $error("ram selected during quiet measurement");
            AST_DIR_FIXED: assert property (@(posedge sys_clk) disable iff (!rst_n)
                testMode && $past(testMode) |-> $stable(directPinOe[r]))
                else $error("shared pin direction changed in test mode");
            // only compare while test mode stood on both edges, else the user address shows
            AST_NO_LATENCY: assert property (@(posedge sys_clk) disable iff (!rst_n)
                testMode && $past(testMode) && $changed(direct_address_in_0[PIN])
                    |-> ramReq[r].address != $past(ramReq[r].address))
                else $error("ram address lags the direct pin");

            // normal mode: ram data and shared pins belong to the user logic; test mode: unpicked rams stay deselected
            AST_USER_DATA: assert property (@(posedge sys_clk) disable iff (!rst_n)
                userRamOut[r] == ramOut[r])
                else $error("ram data not passed to user logic");
            AST_PIN_SHARE: assert property (@(posedge sys_clk) disable iff (!rst_n)
                !testMode |-> direct_ram_out_0[r] == userPinOut0[r]
                    && direct_ram_out_1[r] == userPinOut1[r] && directPinOe[r] == userPinOe[r])
                else $error("shared pin not driven by user logic in normal mode");
            AST_PIN_IN: assert property (@(posedge sys_clk) disable iff (!rst_n)
                !testMode |-> userPinIn0[r] == funcPinIn0[r] && userPinIn1[r] == funcPinIn1[r])
                else $error("shared pin input not passed to user logic");
            AST_SHARE_PICK: assert property (@(posedge sys_clk) disable iff (!rst_n)
                testMode && !ramSel |-> !ramReq[r].chipSelect)
                else $error("unpicked ram selected on shared pins");
        end
    endgenerate

    // injection pin synchroniser; only stages 1 and 2 are compared
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            injectSync <= 3'h0;
        else
            injectSync <= {injectSync[1:0], stageClockInject};
    end

    // rise of the agreed level, so one long pin pulse steps only once
    assign injectEdge = injectSync[2] & injectSync[1] & ~lowStep;

    // stage boundary: upper half can be stepped directly, shortening patterns
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            lowStep <= 1'b0;
        else
            lowStep <= injectSync[2] & injectSync[1];
    end

    // low half wraps into the upper half
    assign lowCarry = userCountStep & (&lowNibble);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            lowNibble  <= CNT_RESET[`RTAM_CNT_W/2-1:0];
            highNibble <= CNT_RESET[`RTAM_CNT_W-1:`RTAM_CNT_W/2];
            highStep   <= 2'h0;
        end
        else
        begin
            lowNibble  <= lowNibble + (userCountStep ? 2'h1 : 2'h0);
            // limitation: a carry and an injection in one cycle count once
            highNibble <= highNibble + ((lowCarry | (testMode & injectEdge)) ? 2'h1 : 2'h0);
            highStep   <= {highStep[0], lowCarry};
        end
    end

    // internal carry exposed so testers need not count through it
    assign stageCount    = {highNibble, lowNibble};
    assign stageCarryMon = highStep[1];

    AST_RESET_INIT: assert property (@(posedge sys_clk)
        !rst_n |=> stageCount == `RTAM_CNT_RESET)
        else $error("counter not initialised by reset");
    AST_INJECT_STEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        testMode && injectEdge && !lowCarry |=> highNibble == $past(highNibble) + 2'h1)
        else $error("injected clock did not step upper stage");
    // one step per pin rise, none from the pin outside test mode, carry seen two edges late
    AST_INJECT_ONCE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        injectEdge |=> !injectEdge)
        else $error("one pin rise stepped the upper stage twice");
    AST_HOLD_NORMAL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !testMode && !lowCarry |=> highNibble == $past(highNibble))
        else $error("upper stage moved without carry in normal mode");
    AST_CARRY_MON: assert property (@(posedge sys_clk) disable iff (!rst_n)
        stageCarryMon == ($past(rst_n) && $past(rst_n, 2) && $past(lowCarry, 2)))
        else $error("carry monitor does not follow the low half carry");

    // quiet measurement exists only inside ram test mode
    AST_QUIET_IN_TEST: assert property (@(posedge sys_clk) disable iff (!rst_n)
        quietAll |-> testMode)
        else $error("quiet measurement outside ram test mode");

endmodule : rtam_access_mux

// >>> verilog/rtam_defs.svh
`ifndef RTAM_DEFS_SVH
`define RTAM_DEFS_SVH

// geometry of the example memory: two words of two bits
`define RTAM_ADDR_W     1
`define RTAM_DATA_W     2
`define RTAM_NUM_RAMS   2

// reset values of the counter test fixture
`define RTAM_CNT_RESET  4'h0
`define RTAM_CNT_W      4

// select encodings for the direct pins when rams share them
`define RTAM_SEL_W      1

`endif

// >>> verilog/rtam_pkg.sv
package rtam_pkg;

    `include "rtam_defs.svh"

    // one ram port as the multiplexer sees it
    typedef struct packed {
        logic                     chipSelect;
        logic                     readWrite;
        logic [`RTAM_ADDR_W-1:0]  address;
        logic [`RTAM_DATA_W-1:0]  dataIn;
    } rtam_ram_req_t;

    // test access mode of the block
    typedef enum logic [1:0] {
        RTAM_MODE_NORMAL  = 2'b00,
        RTAM_MODE_ACCESS  = 2'b01,
        RTAM_MODE_QUIET   = 2'b10
    } rtam_mode_t;

endpackage : rtam_pkg

// >>> verilog/rtam_ram_select.sv
`timescale 1ns/1ps

// combinational steering of one ram port between user logic and the direct pins
module rtam_ram_select
    import rtam_pkg::*;
(
    input  wire logic          accessSelect,
    input  wire logic          quietAll,
    input  wire rtam_ram_req_t userReq,
    input  wire rtam_ram_req_t directReq,
    output rtam_ram_req_t      ramReq
);

    wire rtam_ram_req_t chosenReq;

    // plain mux, no storage on the ram path
    assign chosenReq = accessSelect ? directReq : userReq;

    // quiet forces the select low so the ram sits in standby
    assign ramReq = '{chipSelect: chosenReq.chipSelect & ~quietAll,
                      readWrite:  chosenReq.readWrite,
                      address:    chosenReq.address,
                      dataIn:     chosenReq.dataIn};

endmodule : rtam_ram_select
